// ### rtl/vwc_map.svh
// Register offsets, field positions and reset values of the cache block
`ifndef VWC_MAP_SVH
`define VWC_MAP_SVH

`define VWC_OFS_ID          12'h000
`define VWC_OFS_FLUSH       12'h004
`define VWC_OFS_CTRL        12'h008
`define VWC_OFS_CACHEABLE   12'h00C
`define VWC_OFS_UPDATEABLE  12'h010
`define VWC_OFS_DISRUPT     12'h014

`define VWC_CTRL_ON         0
`define VWC_CTRL_SHARED     1
`define VWC_CTRL_MONITOR    2
`define VWC_CTRL_W          3
`define VWC_CTRL_RST        3'h0
`define VWC_AREA_RST        32'h0000_0000

`define VWC_LINES           256
`define VWC_WAYS            64
`define VWC_LINE_WORDS      4
`define VWC_WORD_LSB        2
`define VWC_SET_LSB         4
`define VWC_TAG_LSB         6
`define VWC_REGION_LSB      21
`define VWC_TAG_W           20
`define VWC_LFSR_RST        6'h01
`define VWC_LAST_WORD       2'h3

`endif

// ### rtl/vwc_pkg.sv
// Types shared by the cache block
package vwc_pkg;

    typedef struct packed {
        logic        we;
        logic        byte_sel;
        logic [25:0] addr;
        logic [31:0] wdata;
    } vwc_core_cmd_t;

    typedef struct packed {
        logic        we;
        logic        byte_sel;
        logic        line;
        logic [25:0] addr;
        logic [31:0] wdata;
    } vwc_mem_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HIT,
        ST_WAIT,
        ST_FILL
    } vwc_state_t;

    typedef enum logic [1:0] {
        MS_IDLE,
        MS_REQ,
        MS_GAP
    } vwc_mstate_t;

endpackage : vwc_pkg

// ### rtl/vwc_mem.sv
// Single-port data store with byte write enables and registered read data
`timescale 1ns/1ps
module vwc_mem #(
    parameter int AW = 10,
    parameter int NB = 4
) (
    input  wire  logic              i_clk,
    input  wire  logic [NB-1:0]     i_be,
    input  wire  logic [AW-1:0]     i_addr,
    input  wire  logic [NB*8-1:0]   i_wdata,
    output logic       [NB*8-1:0]   o_rdata
);
    logic [NB*8-1:0] mem [2**AW];

    // Read returns the old word when a write hits the same address
    always_ff @(posedge i_clk) begin
        o_rdata <= mem[i_addr];
    end

    for (genvar b = 0; b < NB; b++) begin : g_lane
        always_ff @(posedge i_clk) begin
            if (i_be[b]) begin
                mem[i_addr][b*8 +: 8] <= i_wdata[b*8 +: 8];
            end
        end
    end
endmodule : vwc_mem

// ### rtl/vwc_cache.sv
// Virtual-address write-through cache with APB control and memory link
`timescale 1ns/1ps
`include "vwc_map.svh"
module vwc_cache #(
    parameter logic [31:0] ID_VALUE = 32'h5A5A_0001, // Arbitrary value
    parameter int          ADDR_W   = 26
) (
    input  wire  logic                   I_CLK,
    input  wire  logic                   I_RESET_N,
    input  wire  logic                   I_PSEL,
    input  wire  logic                   I_PENABLE,
    input  wire  logic                   I_PWRITE,
    input  wire  logic [11:0]            I_PADDR,
    input  wire  logic [31:0]            I_PWDATA,
    output logic       [31:0]            O_PRDATA,
    output logic                         O_PREADY,
    output logic                         O_PSLVERR,
    input  wire  logic                   I_CORE_REQ,
    input  wire  vwc_pkg::vwc_core_cmd_t I_CORE_CMD,
    output logic                         O_CORE_ACK,
    output logic       [31:0]            O_CORE_RDATA,
    input  wire  logic                   I_MCLK,
    output logic                         O_MEM_REQ,
    output vwc_pkg::vwc_core_cmd_t       O_MEM_CMD,
    input  wire  logic                   I_MEM_ACK,
    input  wire  logic [31:0]            I_MEM_RDATA
);
    import vwc_pkg::*;

    if (ADDR_W != 26) begin : g_chk
        $error("vwc_cache serves a 26-bit virtual space only");
    end

    // Control registers
    logic [`VWC_CTRL_W-1:0] ctrl_reg;
    logic [31:0]            cacheable_reg;
    logic [31:0]            updateable_reg;
    logic [31:0]            disrupt_reg;
    logic [31:0]            prdata_reg;
    logic                   pready_reg;
    logic                   pslverr_reg;

    // Core domain state
    vwc_state_t             state_reg;
    vwc_mem_cmd_t           mcmd_reg;
    logic                   req_tgl_reg;
    logic                   ack_s1_reg;
    logic                   ack_s2_reg;
    logic [1:0]             word_reg;
    logic [5:0]             victim_reg;
    logic [5:0]             lfsr_reg;
    logic [1:0]             fill_cnt_reg;
    logic                   fill_ok_reg;
    logic                   ack_reg;
    logic [31:0]            rdata_reg;
    logic [`VWC_TAG_W-1:0]  tag_reg [`VWC_LINES];
    logic [`VWC_LINES-1:0]  valid_reg;

    // Memory clock domain state
    logic                   mrst_s1_reg;
    logic                   mrst_n;
    logic                   rq_s1_reg;
    logic                   rq_s2_reg;
    logic                   rq_seen_reg;
    logic                   mack_tgl_reg;
    vwc_mstate_t            mst_reg;
    logic [1:0]             mcnt_reg;
    logic                   mline_reg;
    logic                   mem_req_reg;
    vwc_core_cmd_t          mem_cmd_reg;
    logic [31:0]            buf_reg [`VWC_LINE_WORDS];

    // Lookup on the incoming virtual address
    logic                   hit;
    logic [5:0]             hit_way;
    wire  [25:0] in_addr   = I_CORE_CMD.addr;
    wire  [1:0]  in_set    = in_addr[`VWC_SET_LSB +: 2];
    wire  [1:0]  in_word   = in_addr[`VWC_WORD_LSB +: 2];
    wire  [4:0]  in_region = in_addr[`VWC_REGION_LSB +: 5];
    wire  [`VWC_TAG_W-1:0] in_tag = in_addr[25:`VWC_TAG_LSB];

    always_comb begin
        hit     = 1'b0;
        hit_way = 6'h00;
        for (int w = 0; w < `VWC_WAYS; w++) begin
            if (valid_reg[{in_set, 6'(w)}] &&
                tag_reg[{in_set, 6'(w)}] == in_tag) begin
                hit     = 1'b1;
                hit_way = 6'(w);
            end
        end
    end

    wire cache_on    = ctrl_reg[`VWC_CTRL_ON];
    wire take        = (state_reg == ST_IDLE) && I_CORE_REQ && !ack_reg;
    wire take_wr     = take && I_CORE_CMD.we;
    wire in_cacheable = cacheable_reg[in_region];
    wire read_hit    = take && !I_CORE_CMD.we && hit && cache_on;
    // Update follows valid data even with the cache off
    wire upd_write   = take_wr && hit && updateable_reg[in_region];
    wire disrupt_fl  = take_wr && disrupt_reg[in_region];
    wire line_fetch  = !I_CORE_CMD.we && cache_on && in_cacheable;
    wire [3:0] wr_be = I_CORE_CMD.byte_sel ?
                       4'(4'h1 << in_addr[1:0]) : 4'hF;
    wire [31:0] wr_lane = I_CORE_CMD.byte_sel ?
                          {4{I_CORE_CMD.wdata[7:0]}} : I_CORE_CMD.wdata;

    // APB decode
    wire apb_setup = I_PSEL && !I_PENABLE;
    wire apb_wr    = I_PSEL && I_PENABLE && I_PWRITE && pready_reg;
    wire apb_flush = apb_wr && (I_PADDR == `VWC_OFS_FLUSH);
    wire flush     = apb_flush || disrupt_fl;
    wire mapped    = (I_PADDR == `VWC_OFS_ID) ||
                     (I_PADDR == `VWC_OFS_FLUSH) ||
                     (I_PADDR == `VWC_OFS_CTRL) ||
                     (I_PADDR == `VWC_OFS_CACHEABLE) ||
                     (I_PADDR == `VWC_OFS_UPDATEABLE) ||
                     (I_PADDR == `VWC_OFS_DISRUPT);
    wire [31:0] rd_mux =
        (I_PADDR == `VWC_OFS_ID)         ? ID_VALUE :
        (I_PADDR == `VWC_OFS_CTRL)       ? {29'h0, ctrl_reg} :
        (I_PADDR == `VWC_OFS_CACHEABLE)  ? cacheable_reg :
        (I_PADDR == `VWC_OFS_UPDATEABLE) ? updateable_reg :
        (I_PADDR == `VWC_OFS_DISRUPT)    ? disrupt_reg : 32'h0000_0000;

    // Data store port
    wire fill_wr  = (state_reg == ST_FILL);
    wire [7:0] fill_idx = {mcmd_reg.addr[`VWC_SET_LSB +: 2], victim_reg};
    wire fill_set = fill_wr && (fill_cnt_reg == `VWC_LAST_WORD) &&
                    fill_ok_reg;
    wire [3:0]  mem_be    = fill_wr ? 4'hF : (upd_write ? wr_be : 4'h0);
    wire [9:0]  mem_addr  = fill_wr ? {fill_idx, fill_cnt_reg} :
                            {in_set, hit_way, in_word};
    wire [31:0] mem_wdata = fill_wr ? buf_reg[fill_cnt_reg] : wr_lane;
    logic [31:0] mem_q;

    vwc_mem #(
        .AW (10),
        .NB (4)
    ) u_mem (
        .i_clk   (I_CLK),
        .i_be    (mem_be),
        .i_addr  (mem_addr),
        .i_wdata (mem_wdata),
        .o_rdata (mem_q)
    );

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ctrl_reg       <= `VWC_CTRL_RST;
            cacheable_reg  <= `VWC_AREA_RST;
            updateable_reg <= `VWC_AREA_RST;
            disrupt_reg    <= `VWC_AREA_RST;
        end else if (apb_wr) begin
            if (I_PADDR == `VWC_OFS_CTRL)
                ctrl_reg <= I_PWDATA[`VWC_CTRL_W-1:0];
            if (I_PADDR == `VWC_OFS_CACHEABLE)
                cacheable_reg <= I_PWDATA;
            if (I_PADDR == `VWC_OFS_UPDATEABLE)
                updateable_reg <= I_PWDATA;
            if (I_PADDR == `VWC_OFS_DISRUPT)
                disrupt_reg <= I_PWDATA;
        end
    end

    // Zero-wait slave: answer is prepared during the setup cycle
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= apb_setup;
            pslverr_reg <= apb_setup && !mapped;
            if (apb_setup)
                prdata_reg <= I_PWRITE ? 32'h0000_0000 : rd_mux;
        end
    end

    // Flush wins over a fill that completes in the same cycle
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N)
            valid_reg <= '0;
        else if (flush)
            valid_reg <= '0;
        else if (fill_set)
            valid_reg[fill_idx] <= 1'b1;
    end

    always_ff @(posedge I_CLK) begin
        if (fill_set)
            tag_reg[fill_idx] <= mcmd_reg.addr[25:`VWC_TAG_LSB];
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            lfsr_reg   <= `VWC_LFSR_RST;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            lfsr_reg   <= {lfsr_reg[4:0], ^lfsr_reg[5:4]};
            ack_s1_reg <= mack_tgl_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_reg    <= ST_IDLE;
            mcmd_reg     <= '0;
            req_tgl_reg  <= 1'b0;
            word_reg     <= 2'h0;
            victim_reg   <= 6'h00;
            fill_cnt_reg <= 2'h0;
            fill_ok_reg  <= 1'b0;
            ack_reg      <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
        end else begin
            ack_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (read_hit) begin
                        state_reg <= ST_HIT;
                    end else if (take) begin
                        // Writes go out whether or not they hit
                        mcmd_reg <= '{we:       I_CORE_CMD.we,
                                      byte_sel: I_CORE_CMD.byte_sel,
                                      line:     line_fetch,
                                      addr:     line_fetch ?
                                          {in_addr[25:4], 4'h0} : in_addr,
                                      wdata:    wr_lane};
                        req_tgl_reg <= ~req_tgl_reg;
                        word_reg    <= in_word;
                        victim_reg  <= lfsr_reg;
                        fill_ok_reg <= line_fetch;
                        state_reg   <= ST_WAIT;
                    end
                end
                ST_HIT: begin
                    rdata_reg <= mem_q;
                    ack_reg   <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                ST_WAIT: begin
                    if (ack_s2_reg == req_tgl_reg) begin
                        if (mcmd_reg.line) begin
                            fill_cnt_reg <= 2'h0;
                            state_reg    <= ST_FILL;
                        end else begin
                            // Single word, nothing allocated
                            rdata_reg <= buf_reg[0];
                            ack_reg   <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_FILL: begin
                    fill_cnt_reg <= fill_cnt_reg + 2'h1;
                    if (fill_cnt_reg == `VWC_LAST_WORD) begin
                        rdata_reg <= buf_reg[word_reg];
                        ack_reg   <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
            // A flush during a fetch makes the fetched line stale
            if (flush)
                fill_ok_reg <= 1'b0;
        end
    end

    // Memory clock domain: reset release synchronised to the link clock
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            mrst_s1_reg <= 1'b0;
            mrst_n      <= 1'b0;
        end else begin
            mrst_s1_reg <= 1'b1;
            mrst_n      <= mrst_s1_reg;
        end
    end

    // Command words stay still in the core domain until the toggle returns
    always_ff @(posedge I_MCLK or negedge mrst_n) begin
        if (!mrst_n) begin
            rq_s1_reg    <= 1'b0;
            rq_s2_reg    <= 1'b0;
            rq_seen_reg  <= 1'b0;
            mack_tgl_reg <= 1'b0;
            mst_reg      <= MS_IDLE;
            mcnt_reg     <= 2'h0;
            mline_reg    <= 1'b0;
            mem_req_reg  <= 1'b0;
            mem_cmd_reg  <= '0;
            for (int i = 0; i < `VWC_LINE_WORDS; i++)
                buf_reg[i] <= 32'h0000_0000;
        end else begin
            rq_s1_reg <= req_tgl_reg;
            rq_s2_reg <= rq_s1_reg;
            unique case (mst_reg)
                MS_IDLE: begin
                    if (rq_s2_reg != rq_seen_reg) begin
                        rq_seen_reg <= rq_s2_reg;
                        mem_cmd_reg <= '{we:       mcmd_reg.we,
                                         byte_sel: mcmd_reg.byte_sel,
                                         addr:     mcmd_reg.addr,
                                         wdata:    mcmd_reg.wdata};
                        mline_reg   <= mcmd_reg.line;
                        mcnt_reg    <= 2'h0;
                        mem_req_reg <= 1'b1;
                        mst_reg     <= MS_REQ;
                    end
                end
                MS_REQ: begin
                    if (I_MEM_ACK) begin
                        mem_req_reg       <= 1'b0;
                        buf_reg[mcnt_reg] <= I_MEM_RDATA;
                        if (!mline_reg || mcnt_reg == `VWC_LAST_WORD) begin
                            mack_tgl_reg <= rq_seen_reg;
                            mst_reg      <= MS_IDLE;
                        end else begin
                            mcnt_reg <= mcnt_reg + 2'h1;
                            mem_cmd_reg.addr[`VWC_WORD_LSB +: 2] <=
                                mcnt_reg + 2'h1;
                            mst_reg  <= MS_GAP;
                        end
                    end
                end
                MS_GAP: begin
                    mem_req_reg <= 1'b1;
                    mst_reg     <= MS_REQ;
                end
            endcase
        end
    end

    assign O_PRDATA     = prdata_reg;
    assign O_PREADY     = pready_reg;
    assign O_PSLVERR    = pslverr_reg;
    assign O_CORE_ACK   = ack_reg;
    assign O_CORE_RDATA = rdata_reg;
    assign O_MEM_REQ    = mem_req_reg;
    assign O_MEM_CMD    = mem_cmd_reg;
endmodule : vwc_cache

// ### test/vwc_cache_properties.sv
// Port-level checks of the cache block
`timescale 1ns/1ps
`include "vwc_map.svh"
module vwc_cache_properties (
    input wire logic                   I_CLK,
    input wire logic                   I_RESET_N,
    input wire logic                   I_PSEL,
    input wire logic                   I_PENABLE,
    input wire logic                   I_PWRITE,
    input wire logic [11:0]            I_PADDR,
    input wire logic [31:0]            I_PWDATA,
    input wire logic [31:0]            O_PRDATA,
    input wire logic                   O_PREADY,
    input wire logic                   I_CORE_REQ,
    input wire vwc_pkg::vwc_core_cmd_t I_CORE_CMD,
    input wire logic                   O_CORE_ACK,
    input wire logic                   I_MCLK,
    input wire logic                   O_MEM_REQ,
    input wire vwc_pkg::vwc_core_cmd_t O_MEM_CMD,
    input wire logic                   I_MEM_ACK
);
    import vwc_pkg::*;
    logic [2:0]  ctrl_reg;
    logic [31:0] dis_reg;
    logic [7:0]  wait_reg;
    logic        seen_reg;
    logic        flush_reg;
    wire acc = I_PSEL && I_PENABLE && O_PREADY;
    wire wr_acc = acc && I_PWRITE;
    wire rd_ctrl = acc && !I_PWRITE && I_PADDR == `VWC_OFS_CTRL;
    wire dis_hit = O_CORE_ACK && I_CORE_CMD.we
                   && dis_reg[I_CORE_CMD.addr[25:21]];
    // The memory request stands longer than a core period, so sampling
    // it on the core clock never misses a transfer
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ctrl_reg <= 3'h0;
            dis_reg <= 32'h0;
            wait_reg <= 8'h00;
            seen_reg <= 1'b0;
            flush_reg <= 1'b0;
        end else begin
            if (wr_acc && I_PADDR == `VWC_OFS_CTRL)
                ctrl_reg <= I_PWDATA[2:0];
            if (wr_acc && I_PADDR == `VWC_OFS_DISRUPT)
                dis_reg <= I_PWDATA;
            wait_reg <= (I_CORE_REQ && !O_CORE_ACK) ? wait_reg + 8'h01 : 8'h00;
            seen_reg <= O_MEM_REQ || (seen_reg && !O_CORE_ACK);
            flush_reg <= (wr_acc && I_PADDR == `VWC_OFS_FLUSH) || dis_hit
                         || (flush_reg && !O_CORE_ACK);
        end
    end
    chk_apb_zero_wait:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_PSEL && !I_PENABLE |=> O_PREADY)
        else $error("register access not answered at once");
    chk_ctrl_readback:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        rd_ctrl |-> O_PRDATA == {29'h0, ctrl_reg})
        else $error("control bits read back wrong");
    chk_hit_two_cycles:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_CORE_ACK |-> seen_reg || wait_reg == 8'h02)
        else $error("answer without memory not two cycles after request");
    chk_write_through:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_CORE_ACK && (I_CORE_CMD.we || !ctrl_reg[0]) |-> seen_reg)
        else $error("write or cache-off read answered without memory");
    chk_flush_refetch:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_CORE_ACK && flush_reg |-> seen_reg)
        else $error("request after flush served from cache");
    chk_ack_pulse:
    assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_CORE_ACK |=> !O_CORE_ACK)
        else $error("core answer longer than one cycle");
    chk_mem_drop:
    assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        O_MEM_REQ && I_MEM_ACK |=> !O_MEM_REQ)
        else $error("memory request not released after its answer");
    chk_mem_hold:
    assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ && $stable(O_MEM_CMD))
        else $error("memory request changed before its answer");
endmodule : vwc_cache_properties
bind vwc_cache vwc_cache_properties vwc_cache_properties_inst (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .I_CORE_REQ(I_CORE_REQ), .I_CORE_CMD(I_CORE_CMD),
    .O_CORE_ACK(O_CORE_ACK), .I_MCLK(I_MCLK), .O_MEM_REQ(O_MEM_REQ),
    .O_MEM_CMD(O_MEM_CMD), .I_MEM_ACK(I_MEM_ACK)
);

// ### test/vwc_mem_model.sv
// Behavioural external memory answering on the memory clock
`timescale 1ns/1ps
module vwc_mem_model (
    input  wire logic                   i_mclk,
    input  wire logic [3:0]             i_delay,
    input  wire logic                   i_req,
    input  wire vwc_pkg::vwc_core_cmd_t i_cmd,
    output logic                        o_ack,
    output logic [31:0]                 o_rdata
);
    import vwc_pkg::*;
    logic [31:0] store [int];
    logic [3:0]  wait_reg = 4'h0;
    int          rd_cnt = 0;
    int          wr_cnt = 0;
    int          k;
    logic [31:0] w;
    initial o_ack = 1'b0;
    initial o_rdata = 32'h0;
    always @(posedge i_mclk) begin
        if (o_ack) begin
            o_ack <= 1'b0;
            // A released data bus must not keep showing the last word
            o_rdata <= ~o_rdata;
        end else if (i_req && wait_reg >= i_delay) begin
            wait_reg <= 4'h0;
            o_ack <= 1'b1;
            k = int'(i_cmd.addr[25:2]);
            if (i_cmd.we) begin
                w = store.exists(k) ? store[k] : {i_cmd.addr[25:2], 8'h5A};
                if (i_cmd.byte_sel)
                    w[8 * i_cmd.addr[1:0] +: 8] = i_cmd.wdata[7:0];
                else
                    w = i_cmd.wdata;
                store[k] = w;
                wr_cnt <= wr_cnt + 1;
            end else begin
                rd_cnt <= rd_cnt + 1;
                if (store.exists(k))
                    o_rdata <= store[k];
                else
                    o_rdata <= {i_cmd.addr[25:2], 8'h5A};
            end
        end else if (i_req) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule : vwc_mem_model

// ### test/vwc_cache_bench.sv
// Self-checking bench for the write-through cache block
`timescale 1ns/1ps
`include "vwc_map.svh"
module vwc_cache_bench;
    import vwc_pkg::*;
    localparam logic [31:0] ID_V = 32'h1234_ABCD; // Arbitrary value
    logic          clk = 1'b0;
    logic          mclk = 1'b0;
    logic          rst_n = 1'b0;
    logic          psel = 1'b0;
    logic          pen = 1'b0;
    logic          pwr = 1'b0;
    logic [11:0]   paddr = 12'h000;
    logic [31:0]   pwdata = 32'h0;
    logic          creq = 1'b0;
    logic          bsel = 1'b0;
    vwc_core_cmd_t ccmd = '0;
    logic [3:0]    delay = 4'h0;
    logic [31:0]   prdata, crdata, mrdata, rd_v, crv;
    logic          pready, pslverr, cack, mreq, mack, err_v;
    vwc_core_cmd_t mcmd;
    int            bad_count = 0;
    int            cmp_count = 0;
    int            cycles = 0;
    always #20 clk = ~clk;
    initial begin
        #7;
        forever #24 mclk = ~mclk;
    end
    vwc_cache #(.ID_VALUE(ID_V)) vwc_cache_inst (
        .I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_CORE_REQ(creq), .I_CORE_CMD(ccmd),
        .O_CORE_ACK(cack), .O_CORE_RDATA(crdata), .I_MCLK(mclk),
        .O_MEM_REQ(mreq), .O_MEM_CMD(mcmd), .I_MEM_ACK(mack),
        .I_MEM_RDATA(mrdata)
    );
    vwc_mem_model vwc_mem_model_inst (
        .i_mclk(mclk), .i_delay(delay), .i_req(mreq),
        .i_cmd(mcmd), .o_ack(mack), .o_rdata(mrdata)
    );
    function automatic logic [31:0] pat(input logic [25:0] a);
        return {a[25:2], 8'h5A};
    endfunction : pat
    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    // Entered just after a rising edge; leaves one edge after release
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", 32'h1, {31'h0, pready});
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check("register", e, rd_v);
    endtask : rd
    task automatic core(input logic w, input logic [25:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        creq <= 1'b1;
        ccmd <= {w, bsel, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (cack !== 1'b1 && n < 400);
        check("core ack", 32'h1, {31'h0, cack});
        crv = crdata;
        creq <= 1'b0;
        @(posedge clk);
    endtask : core
    task automatic rdc(input logic [25:0] a, input logic [31:0] e,
                       input int words);
        int r0;
        r0 = vwc_mem_model_inst.rd_cnt;
        core(1'b0, a, 32'h0);
        check("core data", e, crv);
        check("words read", words, vwc_mem_model_inst.rd_cnt - r0);
    endtask : rdc
    task automatic t_regs;
        rd(`VWC_OFS_ID, ID_V);
        wr(`VWC_OFS_ID, 32'h0);
        rd(`VWC_OFS_ID, ID_V);
        rd(`VWC_OFS_CTRL, 32'h0);
        for (int i = 3; i < 6; i++) begin
            rd(12'(i * 4), 32'h0);
            wr(12'(i * 4), 32'hA5C3_0F96 + i);
            rd(12'(i * 4), 32'hA5C3_0F96 + i);
        end
        wr(`VWC_OFS_CTRL, 32'hFFFF_FFFF);
        rd(`VWC_OFS_CTRL, 32'h7);
        rd(`VWC_OFS_FLUSH, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err_v});
        check("unmapped data", 32'h0, rd_v);
        $display("test regs done");
    endtask : t_regs
    task automatic t_fetch;
        logic [25:0] a;
        wr(`VWC_OFS_CTRL, 32'h0);
        wr(`VWC_OFS_CACHEABLE, 32'hFFFF_FFFD);
        wr(`VWC_OFS_UPDATEABLE, 32'h1);
        wr(`VWC_OFS_DISRUPT, 32'h0);
        wr(`VWC_OFS_FLUSH, 32'h0);
        rdc(26'h104, pat(26'h104), 1);
        rdc(26'h104, pat(26'h104), 1);
        wr(`VWC_OFS_CTRL, 32'h1);
        delay <= 4'h3;
        for (int s = 0; s < 4; s++) begin
            a = 26'h108 + 26'(s * 16);
            rdc(a, pat(a), 4);
            rdc(a + 26'h4, pat(a + 26'h4), 0);
        end
        rdc(26'h001_0128, pat(26'h001_0128), 4);
        rdc(26'h020_0040, pat(26'h020_0040), 1);
        rdc(26'h020_0040, pat(26'h020_0040), 1);
        delay <= 4'h0;
        $display("test fetch done");
    endtask : t_fetch
    task automatic t_write;
        int w0;
        w0 = vwc_mem_model_inst.wr_cnt;
        core(1'b1, 26'h104, 32'h1111_2222);
        check("writes out", w0 + 1, vwc_mem_model_inst.wr_cnt);
        rdc(26'h104, 32'h1111_2222, 0);
        bsel = 1'b1;
        core(1'b1, 26'h105, 32'h0000_00EE);
        bsel = 1'b0;
        rdc(26'h104, 32'h1111_EE22, 0);
        wr(`VWC_OFS_UPDATEABLE, 32'h0);
        core(1'b1, 26'h10C, 32'h3333_4444);
        rdc(26'h10C, pat(26'h10C), 0);
        wr(`VWC_OFS_UPDATEABLE, 32'h1);
        wr(`VWC_OFS_CTRL, 32'h0);
        core(1'b1, 26'h118, 32'h5555_6666);
        wr(`VWC_OFS_CTRL, 32'h1);
        rdc(26'h118, 32'h5555_6666, 0);
        $display("test write done");
    endtask : t_write
    task automatic t_flush;
        wr(`VWC_OFS_FLUSH, 32'h0);
        rdc(26'h118, 32'h5555_6666, 4);
        rdc(26'h128, pat(26'h128), 4);
        rdc(26'h12C, pat(26'h12C), 0);
        wr(`VWC_OFS_DISRUPT, 32'h8);
        core(1'b1, 26'h060_0000, 32'h7777_8888);
        rdc(26'h12C, pat(26'h12C), 4);
        $display("test flush done");
    endtask : t_flush
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_regs();
        t_fetch();
        t_write();
        t_flush();
        conclude();
    end
endmodule : vwc_cache_bench
